// ---- hw/acr_map.svh ----
/*
  Offsets, field positions and reset values of the bias and channel 1 bank.
  Assumes inclusion by bare name from the register bank.
*/
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ----------------------------------------------------------------------
// Page and register offsets
// ----------------------------------------------------------------------
`define ACR_PAGE_CFG      8'h00
`define ACR_OFS_BIAS      8'h3b
`define ACR_OFS_CH1_IN    8'h3c
`define ACR_OFS_CH_GAIN_CODE  8'h3d
`define ACR_OFS_CH1_VOL   8'h3e

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACR_BIAS_MSB      6
`define ACR_BIAS_LSB      4
`define ACR_FS_MSB        1
`define ACR_FS_LSB        0
`define ACR_INTYP_BIT     7
`define ACR_SRC_MSB       6
`define ACR_SRC_LSB       5
`define ACR_DC_BIT        4
`define ACR_IMP_MSB       3
`define ACR_IMP_LSB       2
`define ACR_ENH_BIT       0
`define ACR_GAIN_MSB      7
`define ACR_GAIN_LSB      2

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define ACR_RST_BIAS      3'h0
`define ACR_RST_FS        2'h0
`define ACR_RST_CH1_IN    8'h00
`define ACR_RST_GAIN      6'h00
`define ACR_RST_VOL       8'hc9
`define ACR_GAIN_MAX      6'h2a

`endif

// ---- hw/acr_pkg.sv ----
/*
  Types shared by the bias and channel 1 register bank.
  Assumes acr_map.svh is on the include path.
*/
package acr_pkg;

  typedef enum logic [2:0] {
    ACR_BIAS_VREF       = 3'b000,
    ACR_BIAS_VREF_X1096 = 3'b001,
    ACR_BIAS_AVDD       = 3'b110,
    ACR_BIAS_NONE       = 3'b111
  } acr_bias_t;

  typedef enum logic [1:0] {
    ACR_FS_2V75  = 2'b00,
    ACR_FS_2V5   = 2'b01,
    ACR_FS_1V375 = 2'b10,
    ACR_FS_NONE  = 2'b11
  } acr_fs_t;

  typedef enum logic [1:0] {
    ACR_SRC_DIFF = 2'b00,
    ACR_SRC_SE   = 2'b01,
    ACR_SRC_PDM  = 2'b10,
    ACR_SRC_NONE = 2'b11
  } acr_src_t;

  typedef enum logic [1:0] {
    ACR_IMP_2K5  = 2'b00,
    ACR_IMP_10K  = 2'b01,
    ACR_IMP_20K  = 2'b10,
    ACR_IMP_NONE = 2'b11
  } acr_imp_t;

  // Decoded settings handed to the analog and digital channel logic.
  typedef struct packed {
    acr_bias_t   mic_bias_select;
    acr_fs_t     full_scale_select;
    logic        line_input;
    acr_src_t    ch_input_source;
    logic        dc_coupled;
    acr_imp_t    ch_impedance_select;
    logic        range_enhancer_on;
    logic        auto_gain_ctrl_on;
    logic [5:0]  gain_db;
    logic        gain_reserved;
    logic [7:0]  volume_code;
  } acr_ctrl_t;

endpackage

// ---- hw/acr_field_reg.sv ----
/*
  One writable register field with a fixed reset value.
  Assumes the write enable and data come from the same clock domain.
*/
`timescale 1ns/1ps
module acr_field_reg #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // Stored value
  output logic      [WIDTH-1:0] value
);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      value <= RESET;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule

// ---- hw/acr_regs.sv ----
/*
  Bias, full-scale and channel 1 configuration register bank on page 0.
  Assumes a simple synchronous register port from the control-port decoder
  and the range enhancer / gain control select bit from register 108.
*/
// Summary of operation
// - Bias code 0 reference, 1 reference times 1.096, 6 supply; 2-5 and 7 reserved.
// - Full-scale code 0 2.75 V, 1 2.5 V, 2 1.375 V; 3 reserved.
// - Bit 7 clear means microphone input, set means line input.
// - Source code 0 differential, 1 single-ended, 2 PDM; 3 reserved.
// - Bit 4 selects AC or DC coupling, analog sources only.
// - Impedance code 0 2.5k, 1 10k, 2 20k ohm; 3 reserved; analog only.
// - Bit 0 clear disables both; set enables one, chosen by register 108 bit 3.
// - Gain bits 7..2 give 0 to 42 dB; codes 43 to 63 reserved.
// - Input configuration register at 0x3c page 0, reset all zeros.
// - Volume register at 0x3e page 0, reset 0xc9.
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_regs
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_page,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // Register 108 bit 3: set picks gain control, clear picks range enhancer
  input  wire logic       enh_agc_select,
  // Decoded settings
  output acr_ctrl_t       ctrl
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic       page_hit;
  logic       wr_bias;
  logic       wr_in;
  logic       wr_gain;
  logic       wr_vol;
  logic [2:0] bias_q;
  logic [1:0] fs_q;
  logic [7:0] in_cfg_q;
  logic [5:0] gain_q;
  logic [7:0] vol_q;
  logic [7:0] in_cfg_wr;

  assign page_hit = (reg_page == `ACR_PAGE_CFG);
  assign wr_bias  = reg_wr_en && page_hit && (reg_addr == `ACR_OFS_BIAS);
  assign wr_in    = reg_wr_en && page_hit && (reg_addr == `ACR_OFS_CH1_IN);
  assign wr_gain  = reg_wr_en && page_hit && (reg_addr == `ACR_OFS_CH_GAIN_CODE);
  assign wr_vol   = reg_wr_en && page_hit && (reg_addr == `ACR_OFS_CH1_VOL);

  // Bit 1 is reserved and never stored.
  assign in_cfg_wr = {reg_wdata[7:2], 1'b0, reg_wdata[0]};

  // ----------------------------------------------------------------------
  // Storage: only field bits are kept
  // ----------------------------------------------------------------------
  acr_field_reg #(.WIDTH(3), .RESET(`ACR_RST_BIAS)) u_bias (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr_bias),
    .wr_data (reg_wdata[`ACR_BIAS_MSB:`ACR_BIAS_LSB]),
    .value   (bias_q)
  );

  acr_field_reg #(.WIDTH(2), .RESET(`ACR_RST_FS)) u_fs (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr_bias),
    .wr_data (reg_wdata[`ACR_FS_MSB:`ACR_FS_LSB]),
    .value   (fs_q)
  );

  acr_field_reg #(.WIDTH(8), .RESET(`ACR_RST_CH1_IN)) u_in (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr_in),
    .wr_data (in_cfg_wr),
    .value   (in_cfg_q)
  );

  acr_field_reg #(.WIDTH(6), .RESET(`ACR_RST_GAIN)) u_gain (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr_gain),
    .wr_data (reg_wdata[`ACR_GAIN_MSB:`ACR_GAIN_LSB]),
    .value   (gain_q)
  );

  acr_field_reg #(.WIDTH(8), .RESET(`ACR_RST_VOL)) u_vol (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr_vol),
    .wr_data (reg_wdata),
    .value   (vol_q)
  );

  // ----------------------------------------------------------------------
  // Read path: unmapped addresses and other pages read zero
  // ----------------------------------------------------------------------
  logic [7:0] rdata_next;
  logic [7:0] rd_addr_reg;

  always_comb begin
    rdata_next = 8'h00;
    if (page_hit) begin
      case (reg_addr)
        `ACR_OFS_BIAS:     rdata_next = {1'b0, bias_q, 2'b00, fs_q};
        `ACR_OFS_CH1_IN:   rdata_next = in_cfg_q;
        `ACR_OFS_CH_GAIN_CODE: rdata_next = {gain_q, 2'b00};
        `ACR_OFS_CH1_VOL:  rdata_next = vol_q;
        default:           rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
      rd_addr_reg  <= 8'h00;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata   <= rdata_next;
        rd_addr_reg <= page_hit ? reg_addr : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decode of fields into settings
  // ----------------------------------------------------------------------
  acr_ctrl_t ctrl_next;
  logic      analog_src;

  assign analog_src = (in_cfg_q[`ACR_SRC_MSB:`ACR_SRC_LSB] == ACR_SRC_DIFF) ||
                      (in_cfg_q[`ACR_SRC_MSB:`ACR_SRC_LSB] == ACR_SRC_SE);

  always_comb begin
    ctrl_next = '0;
    case (bias_q)
      3'h0:    ctrl_next.mic_bias_select = ACR_BIAS_VREF;
      3'h1:    ctrl_next.mic_bias_select = ACR_BIAS_VREF_X1096;
      3'h6:    ctrl_next.mic_bias_select = ACR_BIAS_AVDD;
      default: ctrl_next.mic_bias_select = ACR_BIAS_NONE;
    endcase
    ctrl_next.full_scale_select = acr_fs_t'(fs_q);
    ctrl_next.line_input        = in_cfg_q[`ACR_INTYP_BIT];
    ctrl_next.ch_input_source   = acr_src_t'(in_cfg_q[`ACR_SRC_MSB:`ACR_SRC_LSB]);
    // Coupling and impedance mean nothing on the PDM path.
    ctrl_next.dc_coupled = analog_src && in_cfg_q[`ACR_DC_BIT];
    ctrl_next.ch_impedance_select = analog_src ?
        acr_imp_t'(in_cfg_q[`ACR_IMP_MSB:`ACR_IMP_LSB]) : ACR_IMP_NONE;
    ctrl_next.range_enhancer_on = in_cfg_q[`ACR_ENH_BIT] && !enh_agc_select;
    ctrl_next.auto_gain_ctrl_on = in_cfg_q[`ACR_ENH_BIT] && enh_agc_select;
    // A reserved gain code applies no gain rather than an undefined one.
    ctrl_next.gain_reserved = (gain_q > `ACR_GAIN_MAX);
    ctrl_next.gain_db       = ctrl_next.gain_reserved ? 6'h00 : gain_q;
    ctrl_next.volume_code   = vol_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl                 <= '0;
      ctrl.volume_code     <= `ACR_RST_VOL;
    end else begin
      ctrl <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence in_write_s(logic [7:0] v);
    wr_in && (reg_wdata == v);
  endsequence

  bias_decode_a: assert property (wr_bias && reg_wdata[6:4] == 3'h1 |-> ##2
      ctrl.mic_bias_select == ACR_BIAS_VREF_X1096)
    else $error("bias code 1 not decoded");
  bias_reserved_a: assert property (wr_bias && reg_wdata[6:4] == 3'h3 |-> ##2
      ctrl.mic_bias_select == ACR_BIAS_NONE)
    else $error("reserved bias code drove a bias");
  fs_select_a: assert property (wr_bias |-> ##2
      ctrl.full_scale_select == acr_fs_t'($past(reg_wdata[1:0], 2)))
    else $error("full-scale select not taken");
  src_pdm_a: assert property (in_write_s(8'h5c) |-> ##2
      ctrl.ch_input_source == ACR_SRC_PDM && !ctrl.dc_coupled
      && ctrl.ch_impedance_select == ACR_IMP_NONE && !ctrl.line_input)
    else $error("PDM source kept analog settings");
  src_analog_a: assert property (in_write_s(8'hb8) |-> ##2
      ctrl.line_input && ctrl.ch_input_source == ACR_SRC_SE && ctrl.dc_coupled
      && ctrl.ch_impedance_select == ACR_IMP_20K)
    else $error("analog input fields misdecoded");
  enh_exclusive_a: assert property (!(ctrl.range_enhancer_on && ctrl.auto_gain_ctrl_on)
      && ((ctrl.range_enhancer_on || ctrl.auto_gain_ctrl_on)
          == ($past(in_cfg_q[0]) && $past(rst_n))))
    else $error("enhancer and gain control enable wrong");
  gain_limit_a: assert property (wr_gain |-> ##2
      ctrl.gain_reserved == ($past(reg_wdata[7:2], 2) > 6'h2a)
      && ctrl.gain_db <= 6'h2a)
    else $error("gain code limit broken");
  reserved_zero_a: assert property (reg_rd_valid && rd_addr_reg == 8'h3b
      |-> reg_rdata[7] == 1'b0 && reg_rdata[3:2] == 2'b00)
    else $error("reserved bias bits read nonzero");
  vol_reset_a: assert property ($rose(rst_n) |-> vol_q == 8'hc9 && in_cfg_q == 8'h00)
    else $error("volume or input config reset value wrong");
  read_echo_a: assert property (wr_in ##1 (reg_rd_en && page_hit && reg_addr == 8'h3c)
      |=> reg_rd_valid && reg_rdata == {$past(reg_wdata[7:2], 2), 1'b0, $past(reg_wdata[0], 2)})
    else $error("input config readback mismatch");

endmodule

// ---- verification/acr_regs_bench.sv ----
/*
  Self-checking bench for the bias and channel 1 configuration bank.
  Assumes acr_pkg is compiled first; the bench alone drives every port.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acr_regs_bench;
  import acr_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} acr_row_t;
  logic       clk_sys        = 1'b0;
  logic       rst_n          = 1'b0;
  logic [7:0] reg_page       = 8'h00;
  logic [7:0] reg_addr       = 8'h00;
  logic       reg_wr_en      = 1'b0;
  logic [7:0] reg_wdata      = 8'h00;
  logic       reg_rd_en      = 1'b0;
  logic       enh_agc_select = 1'b0;
  logic [7:0] reg_rdata;
  logic       reg_rd_valid;
  acr_ctrl_t  ctrl;
  acr_ctrl_t  c0;
  acr_bias_t  eb;
  logic [7:0] pg             = 8'h00;
  logic [7:0] d;
  int         num_errors     = 0;
  int         checks         = 0;
  int         cycles         = 0;
  // Writes, then the value that reading the same place must give.
  acr_row_t rows [9] = '{'{8'h3b, 8'hff, 8'h73}, '{8'h3b, 8'h12, 8'h12},
    '{8'h3c, 8'hff, 8'hfd}, '{8'h3c, 8'h5c, 8'h5c}, '{8'h3d, 8'hff, 8'hfc},
    '{8'h3d, 8'ha8, 8'ha8}, '{8'h3e, 8'h00, 8'h00}, '{8'h3e, 8'h55, 8'h55},
    '{8'h3f, 8'hff, 8'h00}};

  acr_regs dut (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .reg_page       (reg_page),
    .reg_addr       (reg_addr),
    .reg_wr_en      (reg_wr_en),
    .reg_wdata      (reg_wdata),
    .reg_rd_en      (reg_rd_en),
    .reg_rdata      (reg_rdata),
    .reg_rd_valid   (reg_rd_valid),
    .enh_agc_select (enh_agc_select),
    .ctrl           (ctrl)
  );

  // ----------------------------------------------------------------------
  // Clock, watchdog and closing report
  // ----------------------------------------------------------------------
  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_sys);
    reg_page  <= pg;
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    reg_page  <= pg;
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    `CHK(reg_rd_valid, 1'b1)
    q = reg_rdata;
  endtask

  // Decoded settings land on the first edge after the write edge.
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic check_reset;
    rd(8'h3b, d); `CHK(d, 8'h00)
    rd(8'h3c, d); `CHK(d, 8'h00)
    rd(8'h3d, d); `CHK(d, 8'h00)
    rd(8'h3e, d); `CHK(d, 8'hc9)
    `CHK(ctrl, c0)
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    c0 = '{ACR_BIAS_VREF, ACR_FS_2V75, 1'b0, ACR_SRC_DIFF, 1'b0, ACR_IMP_2K5,
           1'b0, 1'b0, 6'h00, 1'b0, 8'hc9};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    check_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK(d, rows[i].r)
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h3b, {1'b0, 3'(i), 2'b00, 2'(i)});
      settle();
      eb = (i == 0) ? ACR_BIAS_VREF : (i == 1) ? ACR_BIAS_VREF_X1096 :
           (i == 6) ? ACR_BIAS_AVDD : ACR_BIAS_NONE;
      `CHK(ctrl.mic_bias_select, eb)
      `CHK(ctrl.full_scale_select, acr_fs_t'(2'(i)))
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h3c, {1'b0, 2'(i), 1'b1, 2'b01, 2'b00});
      settle();
      `CHK(ctrl.ch_input_source, acr_src_t'(2'(i)))
      `CHK(ctrl.dc_coupled, (i < 2))
      `CHK(ctrl.ch_impedance_select, (i < 2) ? ACR_IMP_10K : ACR_IMP_NONE)
    end
    wr(8'h3c, 8'h9d);
    settle();
    `CHK(ctrl.line_input, 1'b1)
    `CHK(ctrl.ch_impedance_select, ACR_IMP_NONE)
    `CHK({ctrl.range_enhancer_on, ctrl.auto_gain_ctrl_on}, 2'b10)
    @(posedge clk_sys);
    enh_agc_select <= 1'b1;
    settle();
    `CHK({ctrl.range_enhancer_on, ctrl.auto_gain_ctrl_on}, 2'b01)
    wr(8'h3c, 8'h00);
    settle();
    `CHK({ctrl.range_enhancer_on, ctrl.auto_gain_ctrl_on}, 2'b00)
    `CHK(ctrl.line_input, 1'b0)
    // Write, then read the same register on the very next cycle.
    @(posedge clk_sys);
    reg_addr  <= 8'h3c;
    reg_wdata <= 8'hb8;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    `CHK(reg_rdata, 8'hb8)
    `CHK(ctrl.ch_impedance_select, ACR_IMP_20K)
    `CHK(ctrl.line_input, 1'b1)
    wr(8'h3d, 8'ha8);
    settle();
    `CHK({ctrl.gain_db, ctrl.gain_reserved}, {6'h2a, 1'b0})
    wr(8'h3d, 8'hac);
    settle();
    `CHK({ctrl.gain_db, ctrl.gain_reserved}, {6'h00, 1'b1})
    wr(8'h3e, 8'h55);
    settle();
    `CHK(ctrl.volume_code, 8'h55)
    pg = 8'h01;
    wr(8'h3e, 8'h11);
    rd(8'h3e, d); `CHK(d, 8'h00)
    pg = 8'h00;
    rd(8'h3e, d); `CHK(d, 8'h55)
    @(posedge clk_sys);
    reg_addr  <= 8'h3e;
    reg_wdata <= 8'h77;
    reg_wr_en <= 1'b1;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    #1;
    `CHK(reg_rdata, 8'h55)
    rd(8'h3e, d); `CHK(d, 8'h77)
    @(posedge clk_sys);
    enh_agc_select <= 1'b0;
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    check_reset();
    tally_and_finish();
  end
endmodule
